//--- hdl/lbr_pkg.sv
package lbr_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
	localparam int TP_ARM_MS = 30;
	localparam int TP_ARM_TICKS = (TP_ARM_MS + TICK_MS - 1) / TICK_MS;
	localparam int DLY_W = 20;
	localparam logic [DLY_W-1:0] DLY_MIN_MS = 20'h00064;
	localparam logic [DLY_W-1:0] DLY_MAX_MS = 20'h493E0;
	localparam logic [DLY_W-1:0] DWELL_MAX_MS = 20'h007D0;
	localparam logic [DLY_W-1:0] ZERO_MS = 20'h00000;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SPD0 = 8'h04;
	localparam logic [ADDR_W-1:0] REG_TPD0 = 8'h14;
	localparam logic [ADDR_W-1:0] REG_RECLAIM = 8'h24;
	localparam logic [ADDR_W-1:0] REG_DWELL = 8'h28;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h2C;
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h30;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PROG_LSB = 4;
	localparam int CTRL_NSP_LSB = 8;
	localparam int CTRL_NTP_LSB = 12;
	localparam logic [31:0] CTRL_RST = 32'h00003310;
	localparam logic [DLY_W-1:0] DLY_RST = 20'h003E8;
	localparam logic [DLY_W-1:0] DWELL_RST = 20'h001F4;

	typedef enum logic [2:0] {
		LBR_MODE_NONE = 3'h0,
		LBR_MODE_OFF = 3'h1,
		LBR_MODE_INT = 3'h2,
		LBR_MODE_EXT = 3'h3,
		LBR_MODE_BOTH = 3'h4
	} lbr_mode_t;

	typedef enum logic [1:0] {
		LBR_PROG_SP = 2'h0,
		LBR_PROG_TP = 2'h1,
		LBR_PROG_MIX = 2'h2
	} lbr_prog_t;

	typedef enum logic [2:0] {
		LBR_ST_RESET = 3'b000,
		LBR_ST_DELAY = 3'b001,
		LBR_ST_CLOSE = 3'b011,
		LBR_ST_RECLAIM = 3'b010,
		LBR_ST_LOCKOUT = 3'b110
	} lbr_state_t;

	typedef struct packed {
		logic sp;
		logic tp;
	} lbr_init_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} lbr_bus_t;

	// Clamp a delay setting into its legal span
	function automatic logic [DLY_W-1:0] clamp_ms(input logic [DLY_W-1:0] v,
		input logic [DLY_W-1:0] hi);
		if (v < DLY_MIN_MS)
			return DLY_MIN_MS;
		else if (v > hi)
			return hi;
		else
			return v;
	endfunction

endpackage

//--- hdl/lbr_tick.sv
`timescale 1ns/1ps
module lbr_tick import lbr_pkg::*; #(
	parameter int DIV = TICK_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	output logic o_tick
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic tick_d;

	always_comb
	begin
		tick_d = (cnt_q == 32'(DIV - 1));
		cnt_d = tick_d ? 32'h00000000 : cnt_q + 32'h00000001;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cnt_q <= 32'h00000000;
			o_tick <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			o_tick <= tick_d;
		end
	end
endmodule // lbr_tick

//--- hdl/lbr_timer.sv
`timescale 1ns/1ps
module lbr_timer import lbr_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_start,
	input wire logic i_tick,
	input wire logic [DLY_W-1:0] i_ms,
	output logic o_busy,
	output logic o_done
);
	logic [DLY_W-1:0] cnt_q;
	logic [DLY_W-1:0] cnt_d;
	logic busy_d;
	logic done_d;

	always_comb
	begin
		cnt_d = cnt_q;
		busy_d = o_busy;
		done_d = 1'b0;
		if (i_start)
		begin
			cnt_d = i_ms;
			busy_d = 1'b1;
		end
		else if (o_busy && i_tick)
		begin
			if (cnt_q <= DLY_W'(1))
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
				cnt_d = ZERO_MS;
			end
			else
				cnt_d = cnt_q - DLY_W'(1);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cnt_q <= ZERO_MS;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			o_busy <= busy_d;
			o_done <= done_d;
		end
	end
endmodule // lbr_timer

//--- hdl/lbr_recloser.sv
// How it works
// (RULE1) Mode none: never reclose, three-pole trip enable stays low.
// (RULE2) Mode off: ignore all initiates, three-pole trip enable high.
// (RULE3) Internal, external or both sources gate which initiates count.
// (RULE4) Single-pole program starts first reclose only on single-pole initiate.
// (RULE5) Single-pole program: three-pole first initiate goes straight to lockout.
// (RULE6) Trip enable set after first close, at least 30 ms after initiate drops.
// (RULE7) Single-pole trip enable holds until reset state or lockout.
// (RULE8) Up to three more three-pole attempts, each with its own delay.
// (RULE9) Later single-pole program attempts start only on three-pole initiate.
// (RULE10) Four single-pole program delays chosen by attempt number.
// (RULE11) Three-pole program: single-pole first initiate goes to lockout.
// (RULE12) Three-pole program attempts start only on three-pole initiate.
// (RULE13) Three-pole program has up to four attempts with own delays.
// (RULE14) Three-pole program keeps trip enable high all the time; code holds it low in mode none.
// (RULE15) Mixed program follows whichever initiate type arrives first.
// (RULE16) Mixed program reuses both timer sets and both attempt counts.
// (RULE17) External relays deliver separate single and three-pole initiates.
// (RULE18) Attempts after single trip 1..4; first single-pole, rest three-pole.
// (RULE19) Each reclose delay 0.1 to 300.0 s delays its attempt.
// (RULE20) After a close wait reclaim time; a trip then advances or locks out.
// (RULE21) Close output held for dwell time, 0.1 to 2.0 s.
// (RULE22) Lockout holds with no closing until software reset command; code also leaves it for reset state when mode is none or off.
`timescale 1ns/1ps
module lbr_recloser import lbr_pkg::*; #(
	parameter int TICK_DIV = TICK_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_int_single_pole_reclose_initiate,
	input wire logic i_int_three_pole_reclose_initiate,
	input wire logic i_ext_single_pole_reclose_initiate,
	input wire logic i_ext_three_pole_reclose_initiate,
	output logic o_three_pole_trip_enable,
	output logic o_breaker_close,
	output logic o_lockout
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	lbr_bus_t bus;
	logic [31:0] ctrl_q, ctrl_d;
	logic [DLY_W-1:0] spd_q [4];
	logic [DLY_W-1:0] spd_d [4];
	logic [DLY_W-1:0] tpd_q [4];
	logic [DLY_W-1:0] tpd_d [4];
	logic [DLY_W-1:0] reclaim_q, reclaim_d, dwell_q, dwell_d;
	logic [31:0] rdata_d;
	logic reset_cmd;
	lbr_mode_t mode;
	lbr_prog_t prog;
	logic [2:0] n_sp, n_tp;

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign mode = lbr_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
	assign prog = lbr_prog_t'(ctrl_q[CTRL_PROG_LSB +: 2]);
	assign n_sp = ctrl_q[CTRL_NSP_LSB +: 3];
	assign n_tp = ctrl_q[CTRL_NTP_LSB +: 3];
	assign reset_cmd = bus.wr && (bus.addr == REG_CMD) && bus.wdata[0];

	// Attempt counts clamped 1..4
	function automatic logic [2:0] clamp_n(input logic [2:0] v);
		if (v == 3'h0)
			return 3'h1;
		else if (v > 3'h4)
			return 3'h4;
		else
			return v;
	endfunction

	lbr_state_t st_q, st_d;
	logic tpe_q, tpe_d;
	logic lock_q;
	logic close_q;

	always_comb
	begin
		ctrl_d = ctrl_q;
		spd_d = spd_q;
		tpd_d = tpd_q;
		reclaim_d = reclaim_q;
		dwell_d = dwell_q;
		rdata_d = 32'h00000000;
		if (bus.wr)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (bus.addr == REG_SPD0 + ADDR_W'(4 * i))
					spd_d[i] = clamp_ms(bus.wdata[DLY_W-1:0], DLY_MAX_MS); // [RULE19]
				if (bus.addr == REG_TPD0 + ADDR_W'(4 * i))
					tpd_d[i] = clamp_ms(bus.wdata[DLY_W-1:0], DLY_MAX_MS); // [RULE19]
			end
			if (bus.addr == REG_CTRL)
			begin
				ctrl_d = 32'h00000000;
				ctrl_d[CTRL_MODE_LSB +: 3] = bus.wdata[CTRL_MODE_LSB +: 3];
				ctrl_d[CTRL_PROG_LSB +: 2] = bus.wdata[CTRL_PROG_LSB +: 2];
				ctrl_d[CTRL_NSP_LSB +: 3] = clamp_n(bus.wdata[CTRL_NSP_LSB +: 3]); // [RULE18]
				ctrl_d[CTRL_NTP_LSB +: 3] = clamp_n(bus.wdata[CTRL_NTP_LSB +: 3]); // [RULE16]
			end
			if (bus.addr == REG_RECLAIM)
				reclaim_d = clamp_ms(bus.wdata[DLY_W-1:0], DLY_MAX_MS);
			if (bus.addr == REG_DWELL)
				dwell_d = clamp_ms(bus.wdata[DLY_W-1:0], DWELL_MAX_MS); // [RULE21]
		end
		if (bus.rd)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (bus.addr == REG_SPD0 + ADDR_W'(4 * i))
					rdata_d = 32'(spd_q[i]);
				if (bus.addr == REG_TPD0 + ADDR_W'(4 * i))
					rdata_d = 32'(tpd_q[i]);
			end
			if (bus.addr == REG_CTRL)
				rdata_d = ctrl_q;
			if (bus.addr == REG_RECLAIM)
				rdata_d = 32'(reclaim_q);
			if (bus.addr == REG_DWELL)
				rdata_d = 32'(dwell_q);
			if (bus.addr == REG_STATUS)
				rdata_d = {24'h000000, 1'b0, st_q, lock_q, close_q, tpe_q, 1'b0};
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ctrl_q <= CTRL_RST;
			for (int i = 0; i < 4; i++)
			begin
				spd_q[i] <= DLY_RST;
				tpd_q[i] <= DLY_RST;
			end
			reclaim_q <= DLY_RST;
			dwell_q <= DWELL_RST;
			o_rdata <= 32'h00000000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			spd_q <= spd_d;
			tpd_q <= tpd_d;
			reclaim_q <= reclaim_d;
			dwell_q <= dwell_d;
			o_rdata <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// Initiate qualification
	// ---------------------------------------------------------------
	lbr_init_t ini;
	logic use_int, use_ext;

	always_comb
	begin
		use_int = (mode == LBR_MODE_INT) || (mode == LBR_MODE_BOTH); // [RULE3]
		use_ext = (mode == LBR_MODE_EXT) || (mode == LBR_MODE_BOTH); // [RULE3] [RULE17]
		ini.sp = (use_int && i_int_single_pole_reclose_initiate)
			|| (use_ext && i_ext_single_pole_reclose_initiate);
		ini.tp = (use_int && i_int_three_pole_reclose_initiate)
			|| (use_ext && i_ext_three_pole_reclose_initiate);
	end

	// ---------------------------------------------------------------
	// Timers
	// ---------------------------------------------------------------
	logic tick;
	logic dly_start, dly_done, cls_start, cls_done, rcl_start, rcl_done;
	logic [DLY_W-1:0] dly_ms;

	lbr_tick #(.DIV(TICK_DIV)) u_tick (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.o_tick(tick)
	);

	lbr_timer u_dly (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_start(dly_start),
		.i_tick(tick),
		.i_ms(dly_ms),
		.o_busy(),
		.o_done(dly_done)
	);

	lbr_timer u_cls (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_start(cls_start),
		.i_tick(tick),
		.i_ms(dwell_q),
		.o_busy(),
		.o_done(cls_done)
	);

	lbr_timer u_rcl (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_start(rcl_start),
		.i_tick(tick),
		.i_ms(reclaim_q),
		.o_busy(),
		.o_done(rcl_done)
	);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	logic sp_run_q, sp_run_d;
	logic [1:0] att_q, att_d;
	logic [5:0] arm_q, arm_d;
	logic lock_d, close_d;
	logic [2:0] n_lim;

	always_comb
	begin
		st_d = st_q;
		sp_run_d = sp_run_q;
		att_d = att_q;
		arm_d = arm_q;
		tpe_d = tpe_q;
		lock_d = 1'b0;
		close_d = 1'b0;
		dly_start = 1'b0;
		cls_start = 1'b0;
		rcl_start = 1'b0;
		n_lim = sp_run_q ? n_sp : n_tp;
		dly_ms = sp_run_q ? spd_q[att_q] : tpd_q[att_q]; // [RULE10] [RULE13] [RULE16]
		unique case (st_q)
			LBR_ST_RESET:
			begin
				att_d = 2'h0;
				if (ini.sp || ini.tp)
				begin
					if (ini.sp && prog != LBR_PROG_TP)
					begin
						sp_run_d = 1'b1; // [RULE4] [RULE15]
						dly_ms = spd_q[0];
						dly_start = 1'b1;
						st_d = LBR_ST_DELAY;
					end
					else if (ini.tp && !ini.sp && prog != LBR_PROG_SP)
					begin
						sp_run_d = 1'b0; // [RULE12] [RULE15]
						dly_ms = tpd_q[0];
						dly_start = 1'b1;
						st_d = LBR_ST_DELAY;
					end
					else
						st_d = LBR_ST_LOCKOUT; // [RULE5] [RULE11]
				end
			end
			LBR_ST_DELAY:
				if (dly_done) // [RULE19]
				begin
					cls_start = 1'b1;
					st_d = LBR_ST_CLOSE;
				end
			LBR_ST_CLOSE:
			begin
				close_d = 1'b1;
				if (cls_done) // [RULE21]
				begin
					close_d = 1'b0;
					rcl_start = 1'b1;
					st_d = LBR_ST_RECLAIM;
				end
			end
			LBR_ST_RECLAIM:
				if (ini.tp) // [RULE9] [RULE12] [RULE20]
				begin
					if ({1'b0, att_q} + 3'h1 >= n_lim) // [RULE8] [RULE18]
						st_d = LBR_ST_LOCKOUT;
					else
					begin
						att_d = att_q + 2'h1;
						dly_ms = sp_run_q ? spd_q[att_q + 2'h1] : tpd_q[att_q + 2'h1];
						dly_start = 1'b1;
						st_d = LBR_ST_DELAY;
					end
				end
				else if (ini.sp)
					st_d = LBR_ST_LOCKOUT;
				else if (rcl_done)
					st_d = LBR_ST_RESET; // [RULE20]
			LBR_ST_LOCKOUT:
			begin
				lock_d = 1'b1;
				if (reset_cmd)
				begin
					lock_d = 1'b0;
					st_d = LBR_ST_RESET; // [RULE22]
				end
			end
			default:
				st_d = LBR_ST_LOCKOUT;
		endcase
		if (mode == LBR_MODE_NONE || mode == LBR_MODE_OFF)
		begin
			st_d = LBR_ST_RESET; // [RULE1] [RULE2]
			close_d = 1'b0;
			lock_d = 1'b0;
		end
		// Single-pole release timer counts ms since initiate dropped
		if (ini.sp)
			arm_d = 6'h00;
		else if (tick && arm_q < 6'(TP_ARM_TICKS))
			arm_d = arm_q + 6'h01;
		if (mode == LBR_MODE_NONE)
			tpe_d = 1'b0; // [RULE1]
		else if (mode == LBR_MODE_OFF || prog == LBR_PROG_TP)
			tpe_d = 1'b1; // [RULE2] [RULE14]
		else if (st_d == LBR_ST_RESET || st_d == LBR_ST_LOCKOUT)
			tpe_d = 1'b0; // [RULE7]
		else if (sp_run_q && (st_q == LBR_ST_RECLAIM || att_q != 2'h0)
			&& arm_q >= 6'(TP_ARM_TICKS))
			tpe_d = 1'b1; // [RULE6]
		else if (!sp_run_d)
			tpe_d = 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_q <= LBR_ST_RESET;
			sp_run_q <= 1'b0;
			att_q <= 2'h0;
			arm_q <= 6'h00;
			tpe_q <= 1'b0;
			lock_q <= 1'b0;
			close_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			sp_run_q <= sp_run_d;
			att_q <= att_d;
			arm_q <= arm_d;
			tpe_q <= tpe_d;
			lock_q <= lock_d;
			close_q <= close_d;
		end
	end

	assign o_three_pole_trip_enable = tpe_q;
	assign o_breaker_close = close_q;
	assign o_lockout = lock_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);

	none_no_tpe_a: assert property (mode == LBR_MODE_NONE ##1 mode == LBR_MODE_NONE
		|-> !tpe_q && !close_q) else $error("tpe or close in mode none"); // [RULE1]
	off_tpe_a: assert property (mode == LBR_MODE_OFF ##1 mode == LBR_MODE_OFF
		|-> tpe_q && st_q == LBR_ST_RESET) else $error("mode off misbehaves"); // [RULE2]
	src_gate_a: assert property (st_q == LBR_ST_RESET && mode == LBR_MODE_EXT
		&& !i_ext_single_pole_reclose_initiate && !i_ext_three_pole_reclose_initiate
		|=> st_q == LBR_ST_RESET) else $error("internal initiate accepted"); // [RULE3]
	sp_lock_a: assert property (st_q == LBR_ST_RESET && prog == LBR_PROG_SP
		&& mode != LBR_MODE_NONE && mode != LBR_MODE_OFF && ini.tp && !ini.sp
		|=> st_q == LBR_ST_LOCKOUT) else $error("sp program no lockout"); // [RULE5]
	tp_lock_a: assert property (st_q == LBR_ST_RESET && prog == LBR_PROG_TP
		&& mode != LBR_MODE_NONE && mode != LBR_MODE_OFF && ini.sp
		|=> st_q == LBR_ST_LOCKOUT) else $error("tp program no lockout"); // [RULE11]
	tp_tpe_a: assert property (prog == LBR_PROG_TP && mode != LBR_MODE_NONE
		|=> tpe_q) else $error("tp program tpe low"); // [RULE14]
	tpe_arm_a: assert property ($rose(tpe_q) && sp_run_q && prog != LBR_PROG_TP
		&& $past(mode) != LBR_MODE_OFF |-> $past(arm_q) >= 6'(TP_ARM_TICKS))
		else $error("tpe set too early"); // [RULE6]
	close_pulse_a: assert property ($rose(cls_start) |-> ##2 close_q [*2])
		else $error("close not held"); // [RULE21]
	lock_hold_a: assert property (st_q == LBR_ST_LOCKOUT && !reset_cmd
		&& mode != LBR_MODE_NONE && mode != LBR_MODE_OFF
		|=> st_q == LBR_ST_LOCKOUT && !close_q) else $error("lockout left"); // [RULE22]
	att_lim_a: assert property (st_q == LBR_ST_DELAY |-> {1'b0, att_q} < n_lim)
		else $error("too many attempts"); // [RULE8]

	sp_cycle_c: cover property (st_q == LBR_ST_CLOSE && sp_run_q);
	tp_cycle_c: cover property (st_q == LBR_ST_CLOSE && !sp_run_q && att_q == 2'h3);
	lockout_c: cover property (st_q == LBR_ST_LOCKOUT);
	reclaim_c: cover property (st_q == LBR_ST_RECLAIM && rcl_done);
endmodule // lbr_recloser

//--- verification/lbr_ext_relay.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// External relay and breaker close circuit
// ---------------------------------------------------------------
module lbr_ext_relay import lbr_pkg::*; #(
	parameter int HOLD = 20
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire lbr_init_t i_fire,
	input wire logic i_breaker_close,
	output lbr_init_t o_init,
	output logic [7:0] o_close_count
);
	int hold_q;
	logic close_q;
	// Separate single and three-pole initiate lines, held then dropped
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			hold_q <= 0;
			o_init <= '0;
			close_q <= 1'b0;
			o_close_count <= 8'h00;
		end
		else
		begin
			close_q <= i_breaker_close;
			if (i_breaker_close && !close_q)
				o_close_count <= o_close_count + 8'h01;
			if (i_fire != 2'b00)
			begin
				o_init <= i_fire;
				hold_q <= HOLD;
			end
			else if (hold_q > 1)
				hold_q <= hold_q - 1;
			else
			begin
				hold_q <= 0;
				o_init <= '0;
			end
		end
	end
endmodule // lbr_ext_relay

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import lbr_pkg::*;;
	localparam int TD = 10;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic int_sp = 1'b0;
	logic int_tp = 1'b0;
	lbr_init_t ext_fire = '0;
	lbr_init_t ext_init;
	logic [31:0] rdata;
	logic tpe;
	logic brk_close;
	logic lockout;
	logic [7:0] close_count;
	logic [31:0] lfsr_q = 32'hF4A9A3F6;
	logic t;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int exp_q[$];
	int dly[8];
	// ---------------------------------------------------------------
	// Clock, instances, timeout
	// ---------------------------------------------------------------
	initial
	begin
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	lbr_recloser #(.TICK_DIV(TD)) i_lbr_recloser (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
		.i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
		.i_int_single_pole_reclose_initiate(int_sp),
		.i_int_three_pole_reclose_initiate(int_tp),
		.i_ext_single_pole_reclose_initiate(ext_init.sp),
		.i_ext_three_pole_reclose_initiate(ext_init.tp),
		.o_three_pole_trip_enable(tpe), .o_breaker_close(brk_close), .o_lockout(lockout));
	lbr_ext_relay i_lbr_ext_relay (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
		.i_fire(ext_fire), .i_breaker_close(brk_close), .o_init(ext_init),
		.o_close_count(close_count));
	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			failures++;
			report_and_stop();
		end
	end
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] ctrl(input int m, input int p, input int ns, input int nt);
		return 32'(m) | (32'(p) << 4) | (32'(ns) << 8) | (32'(nt) << 12);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		addr <= a;
		wdata <= d;
		bus_wr <= 1'b1;
		@(posedge i_ref_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		@(posedge i_ref_clk);
		addr <= a;
		bus_rd <= 1'b1;
		@(posedge i_ref_clk);
		bus_rd <= 1'b0;
		#1;
		check(rdata, e);
	endtask
	task automatic fire(input bit ext, input bit sp, input bit tp);
		@(posedge i_ref_clk);
		if (ext)
			ext_fire <= {sp, tp};
		else
		begin
			int_sp <= sp;
			int_tp <= tp;
		end
		@(posedge i_ref_clk);
		ext_fire <= '0;
		fork
			begin
				repeat (20) @(posedge i_ref_clk);
				int_sp <= 1'b0;
				int_tp <= 1'b0;
			end
		join_none
	endtask
	// One reclose attempt timed against the next delay of the model queue
	task automatic attempt(input bit ext, input bit sp, input bit tp, output logic tpe_c);
		int n;
		int ms;
		ms = exp_q.pop_front();
		fire(ext, sp, tp);
		n = 2;
		while (brk_close !== 1'b1 && n < 4000)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		tpe_c = tpe;
		check(n >= (ms - 1) * TD && n <= (ms + 1) * TD + 4, 1'b1);
		n = 0;
		while (brk_close === 1'b1 && n < 4000)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		check(n >= 99 * TD && n <= 101 * TD + 4, 1'b1);
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		rd(REG_CTRL, CTRL_RST);
		rd(REG_STATUS, 32'h0);
		rd(8'h3C, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			lfsr_q = lfsr_next(lfsr_q);
			dly[i] = 100 + int'(lfsr_q[4:0]);
			wr(REG_SPD0 + 8'(4 * i), 32'(dly[i]));
		end
		wr(REG_SPD0, 32'h0);
		dly[0] = 100;
		rd(REG_SPD0, 32'(DLY_MIN_MS));
		wr(REG_TPD0 + 8'h0C, 32'hFFFFF);
		rd(REG_TPD0 + 8'h0C, 32'(DLY_MAX_MS));
		wr(REG_TPD0 + 8'h0C, 32'(dly[7]));
		wr(REG_RECLAIM, 32'h64);
		wr(REG_DWELL, 32'h5);
		rd(REG_DWELL, 32'h64);
		fire(0, 1, 0);
		idle(1500);
		check(close_count, 8'h00);
		check(tpe, 1'b0);
		wr(REG_CTRL, ctrl(1, 1, 2, 4));
		fire(1, 0, 1);
		fire(0, 0, 1);
		idle(1500);
		check(close_count, 8'h00);
		check(tpe, 1'b1);
		wr(REG_CTRL, ctrl(2, 0, 2, 4));
		fire(1, 1, 0);
		idle(200);
		rd(REG_STATUS, 32'h0);
		exp_q = {dly[0], dly[1]};
		attempt(0, 1, 0, t);
		check(t, 1'b0);
		idle(3);
		check(tpe, 1'b1);
		attempt(0, 0, 1, t);
		check(t, 1'b1);
		fire(0, 0, 1);
		idle(5);
		check(lockout, 1'b1);
		idle(1500);
		check(close_count, 8'h02);
		wr(REG_CMD, 32'h1);
		rd(REG_STATUS, 32'h0);
		wr(REG_CTRL, ctrl(4, 0, 2, 4));
		fire(1, 0, 1);
		idle(5);
		check(lockout, 1'b1);
		idle(30);
		wr(REG_CMD, 32'h1);
		wr(REG_CTRL, ctrl(2, 1, 1, 4));
		idle(3);
		check(tpe, 1'b1);
		fire(0, 1, 0);
		idle(5);
		check(lockout, 1'b1);
		idle(30);
		wr(REG_CMD, 32'h1);
		wr(REG_CTRL, ctrl(4, 1, 1, 4));
		exp_q = {dly[4], dly[5], dly[6], dly[7]};
		for (int k = 0; k < 4; k++)
		begin
			attempt(k[0], 0, 1, t);
			check(t, 1'b1);
		end
		fire(0, 0, 1);
		idle(5);
		check(lockout, 1'b1);
		check(close_count, 8'h06);
		idle(30);
		wr(REG_CMD, 32'h1);
		wr(REG_CTRL, ctrl(3, 2, 1, 1));
		fire(0, 0, 1);
		idle(200);
		rd(REG_STATUS, 32'h0);
		exp_q = {dly[4]};
		attempt(1, 0, 1, t);
		check(t, 1'b1);
		idle(100 * TD + 30);
		exp_q = {dly[4]};
		attempt(1, 0, 1, t);
		check(close_count, 8'h08);
		idle(100 * TD + 30);
		exp_q = {dly[0]};
		attempt(1, 1, 0, t);
		check(t, 1'b0);
		fire(1, 0, 1);
		idle(5);
		check(lockout, 1'b1);
		check(close_count, 8'h09);
		report_and_stop();
	end
endmodule // tb_top
